/* File: sim/mem_ctrl_model.sv */
// mem_ctrl_model: command and address driver standing in for the memory controller
// assumes the device samples cmd, bank_addr and addr on rising sys_clk
`timescale 1ns/1ps
module mem_ctrl_model
  import mode_cfg_pkg::*;
#(
  parameter int LOAD_WAIT = 2
)
(
  input  wire logic                        sys_clk,
  output logic [3:0]                       cmd,
  output logic [1:0]                       bank_addr,
  output logic [mode_cfg_pkg::ADDR_W-1:0]  addr
);
  // ==========================================================================
  // command issue
  initial
  begin
    cmd       = 4'hf;
    bank_addr = 2'h0;
    addr      = '0;
  end

  // held for one taking edge, then deselect
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    cmd       <= c;
    bank_addr <= b;
    addr      <= a;
    @(posedge sys_clk);
    cmd       <= 4'hf;
    // released address must not keep showing the old value
    addr      <= ~a;
  endtask : issue

  // only called with no burst running, so all banks count as idle
  task automatic load(input logic [1:0] b, input logic [ADDR_W-1:0] v);
    if (b == BANK_SEL_EXT)
      issue(CMD_LOAD, b, v & 13'h007f);
    else
      issue(CMD_LOAD, b, v & 13'h03ff);
    repeat (LOAD_WAIT) @(posedge sys_clk);
  endtask : load
endmodule : mem_ctrl_model

/* File: sim/tb_mode_burst_ctrl.sv */
// tb_mode_burst_ctrl: self-checking bench for the mode and burst logic
// assumes mem_ctrl_model drives the command pins; clk_en high except one freeze
`timescale 1ns/1ps
module tb_mode_burst_ctrl;
  import mode_cfg_pkg::*;
  logic              sys_clk;
  logic              reset;
  logic              clk_en;
  logic              sleep_exit;
  logic [3:0]        cmd;
  logic [1:0]        bank_addr;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] mode_value;
  logic [EXT_W-1:0]  ext_value;
  logic [2:0]        burst_len_field;
  logic              interleaved;
  logic [2:0]        read_latency_field;
  logic              mode_normal;
  logic              mode_reserved;
  logic              single_write;
  logic              burst_active;
  logic              burst_is_write;
  logic [COL_W-1:0]  burst_col;
  logic              dq_drive_start;
  logic              dq_data_valid;
  int                fails;
  int                n_checks;

  mem_ctrl_model u_mem_ctrl_model (.sys_clk(sys_clk), .cmd(cmd), .bank_addr(bank_addr),
                                   .addr(addr));
  mode_burst_ctrl u_mode_burst_ctrl (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .cmd(cmd), .bank_addr(bank_addr), .addr(addr), .sleep_exit(sleep_exit),
    .mode_value(mode_value), .ext_value(ext_value), .burst_len_field(burst_len_field),
    .interleaved(interleaved), .read_latency_field(read_latency_field),
    .mode_normal(mode_normal), .mode_reserved(mode_reserved), .single_write(single_write),
    .burst_active(burst_active), .burst_is_write(burst_is_write), .burst_col(burst_col),
    .dq_drive_start(dq_drive_start), .dq_data_valid(dq_data_valid));

  // ==========================================================================
  // checking helpers
  task automatic chk_val(input logic [12:0] got, input logic [12:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %b", $time, m, got);
    end
  endtask : chk_bit

  function automatic logic [12:0] mode_word(input logic [2:0] lenc, input logic ilv,
                                            input logic [2:0] latc, input logic ws);
    return {3'h0, ws, 2'h0, latc, ilv, lenc};
  endfunction : mode_word

  // a page burst is a 512-wide block, so one formula serves both kinds
  function automatic logic [8:0] exp_col(input logic [8:0] st, input int len,
                                         input logic ilv, input int k);
    logic [8:0] msk;
    msk = 9'(len - 1);
    if (ilv)
      return (st & ~msk) | ((st ^ 9'(k)) & msk);
    return (st & ~msk) | ((st + 9'(k)) & msk);
  endfunction : exp_col

  // watches every cycle after the taking edge until burst and pulses are over
  task automatic run_burst(input logic [8:0] st, input int len, input logic ilv,
                           input int m, input logic rd);
    for (int k = 0; k <= ((len > m) ? len : m); k++)
    begin
      #1;
      chk_bit(burst_active, k < len, "active");
      if (k < len)
        chk_val(burst_col, exp_col(st, len, ilv, k), "col");
      if (k < len)
        chk_bit(burst_is_write, !rd, "dir");
      chk_bit(dq_drive_start, rd && k == m - 2, "drive");
      chk_bit(dq_data_valid, rd && k == m - 1, "valid");
      @(posedge sys_clk);
    end
  endtask : run_burst

  task automatic print_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // clock, watchdog, tests
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end

  initial
  begin
    logic [2:0]  lenc;
    logic        ilv;
    logic [2:0]  latc;
    logic        ws;
    logic [8:0]  st;
    logic [12:0] w;
    logic [6:0]  e;
    reset      = 1'b1;
    clk_en     = 1'b1;
    sleep_exit = 1'b0;
    fails      = 0;
    n_checks   = 0;
    void'($urandom(35));
    repeat (5) @(posedge sys_clk);
    #1;
    chk_val(mode_value, MODE_RESET, "mode rst");
    chk_val(ext_value, EXT_RESET, "ext rst");
    chk_bit(burst_active, 1'b0, "active rst");
    @(posedge sys_clk);
    reset <= 1'b0;
    // legal codes only; upper bits left zero
    for (int i = 0; i < 16; i++)
    begin
      lenc = 3'(i % 4);
      ilv  = 1'((i / 4) % 2);
      latc = 3'($urandom_range(3, 2));
      ws   = 1'(i / 8);
      st   = (i == 15) ? 9'h1ff : 9'($urandom);
      w    = mode_word(lenc, ilv, latc, ws);
      u_mem_ctrl_model.load(BANK_SEL_MODE, w);
      chk_val(mode_value, w, "mode");
      chk_val(burst_len_field, lenc, "len");
      chk_bit(interleaved, ilv, "type");
      chk_val(read_latency_field, latc, "lat");
      chk_bit(single_write, ws, "wmode");
      chk_bit(mode_normal, 1'b1, "normal");
      u_mem_ctrl_model.issue(CMD_READ, 2'h0, 13'(st));
      run_burst(st, 1 << lenc, ilv, latc, 1'b1);
      u_mem_ctrl_model.issue(CMD_WRITE, 2'h0, 13'(st));
      run_burst(st, ws ? 1 : (1 << lenc), ilv, latc, 1'b0);
    end
    u_mem_ctrl_model.load(2'h1, 13'h0032);
    chk_val(mode_value, w, "bank1 load");
    e = 7'($urandom);
    u_mem_ctrl_model.load(BANK_SEL_EXT, 13'(e));
    chk_val(ext_value, e, "ext");
    chk_val(mode_value, w, "mode kept");
    @(posedge sys_clk);
    sleep_exit <= 1'b1;
    @(posedge sys_clk);
    sleep_exit <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_val(ext_value, e, "ext sleep");
    // page length with interleaved order is refused
    u_mem_ctrl_model.load(BANK_SEL_MODE, mode_word(BL_CODE_PAGE, 1'b1, LAT_CODE_2, 1'b0));
    chk_bit(mode_reserved, 1'b1, "reserved");
    u_mem_ctrl_model.issue(CMD_READ, 2'h0, 13'h0005);
    run_burst(9'h005, 0, 1'b0, 2, 1'b0);
    // reserved latency and reserved operating mode both block bursts
    u_mem_ctrl_model.load(BANK_SEL_MODE, mode_word(BL_CODE_4, 1'b0, 3'h1, 1'b0));
    chk_bit(mode_reserved, 1'b1, "lat reserved");
    u_mem_ctrl_model.issue(CMD_WRITE, 2'h0, 13'h0005);
    run_burst(9'h005, 0, 1'b0, 2, 1'b0);
    u_mem_ctrl_model.load(BANK_SEL_MODE, 13'h01a2);
    chk_bit(mode_normal, 1'b0, "opmode");
    chk_bit(mode_reserved, 1'b1, "opmode reserved");
    u_mem_ctrl_model.issue(CMD_READ, 2'h0, 13'h0005);
    run_burst(9'h005, 0, 1'b0, 2, 1'b0);
    u_mem_ctrl_model.load(BANK_SEL_MODE, mode_word(BL_CODE_PAGE, 1'b0, LAT_CODE_2, 1'b0));
    u_mem_ctrl_model.issue(CMD_READ, 2'h0, 13'h01fc);
    for (int k = 0; k < 7; k++)
    begin
      #1;
      chk_val(burst_col, exp_col(9'h1fc, 512, 1'b0, k), "page col");
      @(posedge sys_clk);
    end
    // a low enable must freeze the running page burst
    clk_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    clk_en <= 1'b1;
    #1;
    chk_val(burst_col, exp_col(9'h1fc, 512, 1'b0, 7), "frozen col");
    chk_bit(burst_active, 1'b1, "frozen active");
    u_mem_ctrl_model.issue(CMD_TERM, 2'h0, 13'h0000);
    #1;
    chk_bit(burst_active, 1'b0, "terminate");
    u_mem_ctrl_model.issue(CMD_TERM, 2'h0, 13'h0000);
    #1;
    chk_bit(burst_active, 1'b0, "idle terminate");
    // mid-run reset restores the safe defaults
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk_val(mode_value, MODE_RESET, "mode rerst");
    chk_bit(burst_active, 1'b0, "active rerst");
    print_verdict();
  end
endmodule : tb_mode_burst_ctrl

/* File: verilog/mode_burst_ctrl.sv */
// mode_burst_ctrl: mode and extended setup registers plus burst column sequencer
// assumes command pins are registered by the caller on sys_clk
//
// Notes on behaviour
// RULE_01 - mode register changes only on a registered load command
// RULE_02 - bits 2:0 length, 3 type, 6:4 latency, 8:7 opmode, 9 write mode
// RULE_03 - controller zeroes bit 10 and up, including select bits
// RULE_04 - controller loads only with banks idle, then waits mode_load_wait
// RULE_05 - lengths 1,2,4,8 both types; page burst sequential only
// RULE_06 - page burst runs until burst terminate
// RULE_07 - fixed burst wraps within block set by upper column bits
// RULE_08 - page burst increments column and wraps at page end
// RULE_09 - type bit zero sequential, one interleaved
// RULE_10 - sequential adds counter to start, interleaved xors counter
// RULE_11 - read latency two or three; other codes reserved
// RULE_12 - drive off edge n+m-1, data valid by edge n+m
// RULE_13 - normal operation only with opmode bits zero
// RULE_14 - write mode bit set makes writes single location
// RULE_15 - load with bank 2'b10 writes extended setup register
// RULE_16 - controller zeroes extended bits 7 and up
// RULE_17 - controller loads extended register only when idle, then waits
// RULE_18 - extended settings survive deepest sleep state
// RULE_19 - temp_comp_refresh_bits ignored; sensor sets refresh rate
// RULE_20 - controller never programs reserved codes; the bench loads some through mem_ctrl_model
// RULE_21 - load captures address present at the same edge
`timescale 1ns/1ps
module mode_burst_ctrl
  import mode_cfg_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  input  wire logic [3:0]                  cmd,
  input  wire logic [1:0]                  bank_addr,
  input  wire logic [mode_cfg_pkg::ADDR_W-1:0] addr,
  input  wire logic                        sleep_exit,
  output logic [mode_cfg_pkg::ADDR_W-1:0]  mode_value,
  output logic [mode_cfg_pkg::EXT_W-1:0]   ext_value,
  output logic [2:0]                       burst_len_field,
  output logic                             interleaved,
  output logic [2:0]                       read_latency_field,
  output logic                             mode_normal,
  output logic                             mode_reserved,
  output logic                             single_write,
  output logic                             burst_active,
  output logic                             burst_is_write,
  output logic [mode_cfg_pkg::COL_W-1:0]   burst_col,
  output logic                             dq_drive_start,
  output logic                             dq_data_valid
);
  import mode_cfg_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic [3:0] burst_mask(input logic [2:0] code);
    unique case (code)
      BL_CODE_2: burst_mask = 4'h1;
      BL_CODE_4: burst_mask = 4'h3;
      BL_CODE_8: burst_mask = 4'h7;
      default:   burst_mask = 4'h0;
    endcase
  endfunction : burst_mask

  function automatic logic [COL_W-1:0] order_col(input logic [COL_W-1:0] start,
                                                 input logic [3:0] cnt,
                                                 input logic [3:0] mask,
                                                 input logic ilv);
    logic [2:0] low;
    low = ilv ? (start[2:0] ^ cnt[2:0]) : 3'(start[2:0] + cnt[2:0]); // RULE_10
    order_col = (start & ~COL_W'(mask)) | (COL_W'(low) & COL_W'(mask)); // RULE_07
  endfunction : order_col

  // ==========================================================================
  // mode and extended setup registers
  logic [ADDR_W-1:0] mode_r, mode_nxt;
  logic [EXT_W-1:0]  ext_r, ext_nxt;
  logic              load_cmd;

  assign load_cmd = (cmd == CMD_LOAD);

  always_comb
  begin
    mode_nxt = mode_r;
    ext_nxt  = ext_r;
    if (load_cmd && bank_addr == BANK_SEL_MODE)
      mode_nxt = addr; // RULE_01 RULE_21
    if (load_cmd && bank_addr == BANK_SEL_EXT)
      ext_nxt = addr[EXT_W-1:0]; // RULE_15
  end

  // sleep_exit does not touch ext_r: settings persist through deep sleep
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      mode_r <= MODE_RESET;
      ext_r  <= EXT_RESET;
    end
    else if (clk_en)
    begin
      mode_r <= mode_nxt;
      ext_r  <= ext_nxt; // RULE_18
    end
  end

  assign mode_value         = mode_r;
  assign ext_value          = ext_r; // RULE_19
  assign burst_len_field    = mode_r[BURST_LEN_LSB +: 3]; // RULE_02
  assign interleaved        = mode_r[BURST_TYPE_BIT]; // RULE_09
  assign read_latency_field = mode_r[LATENCY_LSB +: 3];
  assign single_write       = mode_r[WRITE_MODE_BIT];
  assign mode_normal        = (mode_r[OPMODE_LSB +: 2] == OPMODE_NORMAL); // RULE_13

  logic len_ok, lat_ok;
  // page burst with interleaved type is unsupported
  assign len_ok = (burst_mask(burst_len_field) != 4'h0) || burst_len_field == BL_CODE_1 ||
                  (burst_len_field == BL_CODE_PAGE && !interleaved); // RULE_05
  assign lat_ok = (read_latency_field == LAT_CODE_2) ||
                  (read_latency_field == LAT_CODE_3); // RULE_11
  assign mode_reserved = !(len_ok && lat_ok && mode_normal);

  // ==========================================================================
  // burst sequencer
  burst_state_t      state_r, state_nxt;
  logic [COL_W-1:0]  start_r, start_nxt;
  logic [3:0]        cnt_r, cnt_nxt;
  logic [3:0]        mask_r, mask_nxt;
  logic              page_r, page_nxt;
  logic              ilv_r, ilv_nxt;
  logic              wr_r, wr_nxt;
  logic              is_rd, is_wr, starts;
  logic [3:0]        new_mask;
  logic              new_page;

  assign is_rd  = (cmd == CMD_READ);
  assign is_wr  = (cmd == CMD_WRITE);
  assign starts = (is_rd || is_wr) && !mode_reserved;
  // writes become single location when write mode bit is set
  assign new_mask = (is_wr && single_write) ? 4'h0 : burst_mask(burst_len_field); // RULE_14
  assign new_page = !(is_wr && single_write) && burst_len_field == BL_CODE_PAGE;

  always_comb
  begin
    state_nxt = state_r;
    start_nxt = start_r;
    cnt_nxt   = cnt_r;
    mask_nxt  = mask_r;
    page_nxt  = page_r;
    ilv_nxt   = ilv_r;
    wr_nxt    = wr_r;
    if (starts)
    begin
      // a new command truncates any burst in progress
      state_nxt = BURST_RUN;
      start_nxt = addr[COL_W-1:0];
      cnt_nxt   = 4'h0;
      mask_nxt  = new_mask;
      page_nxt  = new_page;
      ilv_nxt   = interleaved;
      wr_nxt    = is_wr;
    end
    else
    begin
      unique case (state_r)
        BURST_IDLE: state_nxt = BURST_IDLE;
        BURST_RUN:
        begin
          if (cmd == CMD_TERM)
            state_nxt = BURST_IDLE; // RULE_06
          else if (page_r)
            start_nxt = COL_W'(start_r + 1'b1); // RULE_08
          else if (cnt_r == mask_r)
            state_nxt = BURST_IDLE;
          else
            cnt_nxt = cnt_r + 4'h1;
        end
        default: state_nxt = BURST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_r <= BURST_IDLE;
      start_r <= '0;
      cnt_r   <= 4'h0;
      mask_r  <= 4'h0;
      page_r  <= 1'b0;
      ilv_r   <= 1'b0;
      wr_r    <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      start_r <= start_nxt;
      cnt_r   <= cnt_nxt;
      mask_r  <= mask_nxt;
      page_r  <= page_nxt;
      ilv_r   <= ilv_nxt;
      wr_r    <= wr_nxt;
    end
  end

  assign burst_active   = (state_r == BURST_RUN);
  assign burst_is_write = wr_r;
  assign burst_col      = page_r ? start_r : order_col(start_r, cnt_r, mask_r, ilv_r);

  // ==========================================================================
  // read data timing
  read_latency_pipe u_lat (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .clk_en     (clk_en),
    .read_start (is_rd && !mode_reserved),
    .lat_three  (read_latency_field == LAT_CODE_3),
    .drive_start(dq_drive_start),
    .data_valid (dq_data_valid)
  );

  // ==========================================================================
  // checks
  a_mode_hold_stable : assert property (@(posedge sys_clk) disable iff (reset)
    (!load_cmd || !clk_en) |=> $stable(mode_r)) // RULE_01
    else $error("mode register changed without load");

  a_mode_load_capture : assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && load_cmd && bank_addr == BANK_SEL_MODE) |=> mode_r == $past(addr)) // RULE_21
    else $error("mode register did not capture address");

  a_ext_load_capture : assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && load_cmd && bank_addr == BANK_SEL_EXT) |=>
      ext_r == $past(addr[EXT_W-1:0]) && $stable(mode_r)) // RULE_15
    else $error("extended register load wrong");

  a_ext_sleep_keep : assert property (@(posedge sys_clk) disable iff (reset)
    (sleep_exit && !load_cmd) |=> $stable(ext_r)) // RULE_18
    else $error("extended register lost at sleep exit");

  a_burst8_ends : assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && starts && new_mask == 4'h7 && !new_page) ##1
      (clk_en && !starts && cmd != CMD_TERM) [*8] |=> !burst_active) // RULE_07
    else $error("burst of eight did not end");

  a_seq_step : assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && burst_active && !page_r && !ilv_r && !starts && cnt_r != mask_r
      && cmd != CMD_TERM) |=>
      !clk_en || burst_col[2:0] == ((3'($past(burst_col[2:0]) + 3'h1) & mask_r[2:0])
      | ($past(burst_col[2:0]) & ~mask_r[2:0]))) // RULE_10
    else $error("sequential column step wrong");

  a_page_wrap : assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && burst_active && page_r && !starts && cmd != CMD_TERM) |=>
      burst_col == COL_W'($past(burst_col) + 1'b1)) // RULE_08
    else $error("page burst did not advance");

  a_term_stops : assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && burst_active && cmd == CMD_TERM && !starts) |=> !burst_active) // RULE_06
    else $error("terminate did not stop burst");

  a_single_write : assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && is_wr && single_write && !mode_reserved) ##1
      (clk_en && !starts) |=> !burst_active) // RULE_14
    else $error("single write ran longer than one");

  a_no_ilv_page : assert property (@(posedge sys_clk) disable iff (reset)
    (burst_len_field == BL_CODE_PAGE && interleaved) |-> mode_reserved) // RULE_05
    else $error("interleaved page burst accepted");

  a_lat_reserved : assert property (@(posedge sys_clk) disable iff (reset)
    (read_latency_field != LAT_CODE_2 && read_latency_field != LAT_CODE_3)
      |-> mode_reserved) // RULE_11
    else $error("reserved latency accepted");

  a_read_latency : assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && is_rd && !mode_reserved && read_latency_field == LAT_CODE_2)
      ##1 clk_en ##1 clk_en |-> dq_data_valid) // RULE_12
    else $error("read data not valid at latency two");

endmodule : mode_burst_ctrl

/* File: verilog/mode_cfg_pkg.sv */
// mode_cfg_pkg: field layout, codes and timing for the mode register logic
// assumes a single sys_clk domain at 25 MHz
package mode_cfg_pkg;

  // ==========================================================================
  // mode register fields
  localparam int BURST_LEN_LSB  = 0;
  localparam int BURST_TYPE_BIT = 3;
  localparam int LATENCY_LSB    = 4;
  localparam int OPMODE_LSB     = 7;
  localparam int WRITE_MODE_BIT = 9;
  localparam int ADDR_W         = 13;
  localparam int COL_W          = 9;
  localparam int EXT_W          = 7;

  // ==========================================================================
  // codes
  localparam logic [2:0] BL_CODE_1    = 3'h0;
  localparam logic [2:0] BL_CODE_2    = 3'h1;
  localparam logic [2:0] BL_CODE_4    = 3'h2;
  localparam logic [2:0] BL_CODE_8    = 3'h3;
  localparam logic [2:0] BL_CODE_PAGE = 3'h7;
  localparam logic [2:0] LAT_CODE_2   = 3'h2;
  localparam logic [2:0] LAT_CODE_3   = 3'h3;
  localparam logic [1:0] OPMODE_NORMAL = 2'h0;

  // ==========================================================================
  // reset values (contents are undefined at power-up; these are merely safe)
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0021;
  localparam logic [EXT_W-1:0]  EXT_RESET  = 7'h00;

  // ==========================================================================
  // command encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LOAD  = 4'h0;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_TERM  = 4'h6;

  // bank select for load
  localparam logic [1:0] BANK_SEL_MODE = 2'h0;
  localparam logic [1:0] BANK_SEL_EXT  = 2'h2;

  typedef enum logic [1:0] {
    BURST_IDLE = 2'b01,
    BURST_RUN  = 2'b10
  } burst_state_t;

endpackage : mode_cfg_pkg

/* File: verilog/read_latency_pipe.sv */
// read_latency_pipe: delays a read strobe by the programmed latency
// assumes the latency code has been validated as 2 or 3 by the caller
`timescale 1ns/1ps
module read_latency_pipe
  import mode_cfg_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       read_start,
  input  wire logic       lat_three,
  output logic            drive_start,
  output logic            data_valid
);
  import mode_cfg_pkg::*;

  logic [2:0] pipe_r;
  logic [2:0] pipe_nxt;

  always_comb
  begin
    pipe_nxt = {pipe_r[1:0], read_start};
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      pipe_r <= 3'h0;
    else if (clk_en)
      pipe_r <= pipe_nxt;
  end

  // drive begins one edge before data is valid
  assign drive_start = lat_three ? pipe_r[1] : pipe_r[0]; // RULE_12
  assign data_valid  = lat_three ? pipe_r[2] : pipe_r[1]; // RULE_12

  a_drive_before_valid : assert property (@(posedge sys_clk) disable iff (reset)
    (clk_en && drive_start) |=> (!clk_en || data_valid)) // RULE_12
    else $error("data valid did not follow drive start");

endmodule : read_latency_pipe
